// ==== dv/fabric_model.sv ====
// routing fabric model that drives the tile inputs
`timescale 1ns/1ps
`default_nettype none
module fabric_model
   import tile_pkg::*;
(
   // clock
   input  wire logic     clk_in,
   // toward the tile
   output var  tile_in_s fabric_out
);
   initial fabric_out = '0;
   // lines change just after an edge, held to the next apply
   task automatic apply(input tile_in_s v);
      @(posedge clk_in);
      fabric_out <= v;
   endtask : apply
endmodule : fabric_model
`default_nettype wire

// ==== dv/logic_tile_tb.sv ====
// self-checking bench for the logic tile
`timescale 1ns/1ps
`default_nettype none
module logic_tile_tb
   import tile_pkg::*;
;
   logic        clk_in;
   logic        resetn_in;
   avmm_req_s   req;
   avmm_rsp_s   rsp;
   tile_in_s    fab;
   tile_out_s   tout;
   tile_in_s    v;
   int          failures;
   int          n_checks;
   logic [31:0] rd;
   logic [2:0]  e;
   logic [1:0]  cq;
   int          fn [4] = '{0, 1, 2, 6};

   logic_tile u_dut (.clk_in(clk_in), .resetn_in(resetn_in),
      .avmm_in(req), .avmm_out(rsp), .fabric_in(fab), .fabric_out(tout));
   fabric_model u_fab (.clk_in(clk_in), .fabric_out(fab));

   initial
   begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   task automatic chk(input string nm, input logic [31:0] ex,
                      input logic [31:0] got);
      n_checks++;
      if (got !== ex)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk

   task automatic tally_and_finish;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish

   task automatic tick(input int k);
      repeat (k) @(posedge clk_in);
   endtask : tick

   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      req <= '{address: a, read: ~wr, write: wr, byteenable: 4'hf,
               writedata: d};
      do
      begin
         @(posedge clk_in);
         n++;
      end
      while (rsp.waitrequest !== 1'b0 && n < 20);
      q = rsp.readdata;
      req <= '0;
      if (rsp.waitrequest !== 1'b0)
      begin
         failures++;
         tally_and_finish();
      end
      @(posedge clk_in);
   endtask : bus

   // ram access: address and write enable on slice 2, data on 0 and 1
   function automatic tile_in_s ramv(input logic we, input logic [3:0] ad,
                                     input logic [3:0] dt);
      tile_in_s r;
      r = '0;
      r.slice[2].ctl = we;
      {r.slice[2].d[0], r.slice[2].c[0]} = ad[3:2];
      {r.slice[2].b[0], r.slice[2].a[0]} = ad[1:0];
      {r.slice[0].m1, r.slice[0].m0} = dt[1:0];
      {r.slice[1].m1, r.slice[1].m0} = dt[3:2];
      return r;
   endfunction : ramv

   initial
   begin
      resetn_in = 1'b0;
      req = '0;
      failures = 0;
      n_checks = 0;
      tick(2);
      resetn_in <= 1'b1;
      tick(1);
      chk("fabric_out", 32'h0, {9'h0, tout});
      bus(1'b0, OFS_MODE, 32'h0, rd);
      chk("mode", 32'h0, rd);
      bus(1'b0, 8'h40, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
      // logic: every truth table entry of table 0
      bus(1'b1, OFS_LUT_BASE, 32'h0000a5c3, rd);
      for (int n = 0; n < 16; n++)
      begin
         v = '0;
         {v.slice[0].d[0], v.slice[0].c[0]} = 2'(n >> 2);
         {v.slice[0].b[0], v.slice[0].a[0]} = 2'(n);
         v.slice[0].m0 = (n >= 8);
         u_fab.apply(v);
         tick(2);
         chk("lut_f0", 32'((16'ha5c3 >> n) & 1), {31'h0, tout.f[0]});
         chk("five_input_table_sel", (n >= 8) ? 32'h0 : 32'((16'ha5c3 >> n) & 1), {31'h0, tout.ofx[0]});
      end
      // ripple: add, subtract, compare over all operand pairs
      bus(1'b1, OFS_MODE, 32'h1, rd);
      for (int k = 0; k < 4; k++)
      begin
         bus(1'b1, OFS_FUNC, 32'(fn[k]), rd);
         for (int a = 0; a < 4; a++)
            for (int b = 0; b < 4; b++)
            begin
               v = '0;
               v.slice[0].a = 2'(a);
               v.slice[0].b = 2'(b);
               v.carry_in = (fn[k] == 1) || (fn[k] == 2);
               u_fab.apply(v);
               tick(2);
               if (fn[k] == 6)
                  e = {a <= b, a != b, a >= b};
               else
                  e = (fn[k] == 0) ? 3'(a + b) : 3'(a + 4 - b);
               chk("ripple", {29'h0, e}, {29'h0, tout.ofx[0], tout.f[1:0]});
               chk("carry_out", {31'h0, (fn[k] != 6) && e[2]}, {31'h0, tout.carry_out});
            end
      end
      // fast carry: slice 0 generates, slices 1-3 propagate
      bus(1'b1, OFS_MODE, 32'h255, rd);
      bus(1'b1, OFS_FUNC, 32'h0, rd);
      v = '0;
      for (int s = 0; s < SLICES; s++)
         v.slice[s].a = 2'h3;
      v.slice[0].b = 2'h1;
      u_fab.apply(v);
      tick(2);
      chk("fast_carry", 32'h6, {29'h0, tout.carry_out, tout.cgen, tout.cprop});
      // up/down counter: one step each way, then clear and preload
      bus(1'b1, OFS_MODE, 32'h5, rd);
      bus(1'b1, OFS_FUNC, 32'h2d, rd);
      for (int u = 1; u >= 0; u--)
      begin
         v = '0;
         v.slice[0].m0 = 1'b1;
         v.slice[0].ctl = u[0];
         u_fab.apply(v);
         tick(4);
         cq = tout.q[1:0];
         tick(1);
         chk("count", 32'(u ? 2'(cq + 2'h1) : 2'(cq - 2'h1)), 32'(tout.q[1:0]));
      end
      v.cnt_clear = 1'b1;
      u_fab.apply(v);
      tick(4);
      chk("count_clr", 32'h0, 32'(tout.q[3:0]));
      v.cnt_clear = 1'b0;
      v.slice[0].ld = 1'b1;
      v.slice[0].b = 2'h2;
      u_fab.apply(v);
      tick(4);
      chk("count_ld", 32'h2, 32'(tout.q[1:0]));
      bus(1'b1, OFS_FUNC, 32'h3, rd);
      v.slice[0].ld = 1'b0;
      u_fab.apply(v);
      tick(4);
      cq = tout.q[1:0];
      tick(1);
      chk("count_up", 32'(2'(cq + 2'h1)), 32'(tout.q[1:0]));
      // ram: slice 3 refuses ram mode, writes back to back, then reads
      bus(1'b1, OFS_MODE, 32'haa, rd);
      bus(1'b0, OFS_MODE, 32'h0, rd);
      chk("mode_s3", 32'h2a, rd);
      bus(1'b1, OFS_CFG, 32'h1, rd);
      bus(1'b0, OFS_STATUS, 32'h0, rd);
      chk("ram_active", 32'h1, {31'h0, rd[STAT_RAM_BIT]});
      for (int a = 0; a < 4; a++)
         u_fab.apply(ramv(1'b1, 4'(a + 5), 4'(a * 3 + 1)));
      for (int a = 0; a < 4; a++)
      begin
         u_fab.apply(ramv(1'b0, 4'(a + 5), 4'h0));
         tick(2);
         chk("ram", 32'(a * 3 + 1), 32'(tout.f[3:0]));
      end
      // pseudo-dual: write via slice 0, read companion at its own address
      bus(1'b1, OFS_MODE, 32'h12a, rd);
      u_fab.apply(ramv(1'b1, 4'h3, 4'h2));
      v = ramv(1'b0, 4'h0, 4'h0);
      v.slice[1].a = 2'h3;
      v.slice[1].b = 2'h3;
      u_fab.apply(v);
      tick(2);
      chk("pdp_read", 32'h2, 32'(tout.f[3:2]));
      // rom slice: table writes refused once configured
      bus(1'b1, OFS_MODE, 32'hc0, rd);
      bus(1'b1, 8'h18, 32'h1234, rd);
      bus(1'b0, 8'h18, 32'h0, rd);
      chk("rom_table", {16'h0, LUT_RST}, rd);
      tally_and_finish();
   end
endmodule : logic_tile_tb
`default_nettype wire

// ==== inc/tile_pkg.sv ====
// shared constants and types for the logic tile
package tile_pkg;

   localparam int SLICES = 4;
   localparam int LUTS   = 8;

   // slice modes and ripple functions, in register field encoding
   typedef enum logic [1:0] {
      MODE_LOGIC, MODE_RIPPLE, MODE_RAM, MODE_ROM
   } slice_mode_e;

   typedef enum logic [2:0] {
      FN_ADD, FN_SUB, FN_ADDSUB, FN_UP, FN_DOWN, FN_UPDOWN, FN_CMP, FN_MULT
   } ripple_fn_e;

   // register byte offsets
   localparam logic [7:0] OFS_LUT_BASE = 8'h00;
   localparam logic [7:0] OFS_LUT_LAST = 8'h1c;
   localparam logic [7:0] OFS_MODE     = 8'h20;
   localparam logic [7:0] OFS_FUNC     = 8'h24;
   localparam logic [7:0] OFS_CFG      = 8'h28;
   localparam logic [7:0] OFS_STATUS   = 8'h2c;

   // field positions
   localparam int MODE_PSEUDO_DUAL_PORT_RAM_BIT  = 8;
   localparam int MODE_FASTC_BIT = 9;
   localparam int CFG_DONE_BIT   = 0;
   localparam int STAT_RAM_BIT   = 8;
   localparam int STAT_DONE_BIT  = 9;

   // reset values
   localparam logic [15:0] LUT_RST  = 16'h0000;
   localparam logic [1:0]  CNT_RST  = 2'h0;
   localparam logic [31:0] RDAT_RST = 32'h0000_0000;

   // routing side bundles: 50 inputs, 23 outputs
   typedef struct packed {
      logic       ld;
      logic       ctl;
      logic       m1;
      logic       m0;
      logic [1:0] d;
      logic [1:0] c;
      logic [1:0] b;
      logic [1:0] a;
   } slice_in_s;

   typedef struct packed {
      logic                   cnt_clear;
      logic                   carry_in;
      slice_in_s [SLICES-1:0] slice;
   } tile_in_s;

   typedef struct packed {
      logic       carry_out;
      logic       cgen;
      logic       cprop;
      logic [3:0] ofx;
      logic [7:0] q;
      logic [7:0] f;
   } tile_out_s;

   // avalon-mm slave bundles
   typedef struct packed {
      logic [7:0]  address;
      logic        read;
      logic        write;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } avmm_req_s;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } avmm_rsp_s;

endpackage : tile_pkg

// ==== rtl/logic_tile.sv ====
// logic tile: four slices of two four-input tables, config over avalon-mm
`timescale 1ns/1ps
`default_nettype none

module logic_tile
   import tile_pkg::*;
(
   // clock and reset
   input  wire logic      clk_in,
   input  wire logic      resetn_in,
   // register bus
   input  wire avmm_req_s avmm_in,
   output var  avmm_rsp_s avmm_out,
   // routing fabric
   input  wire tile_in_s  fabric_in,
   output var  tile_out_s fabric_out
);

   logic [15:0]  lut_reg [LUTS];
   slice_mode_e  mode_reg [SLICES];
   ripple_fn_e   fn_reg [SLICES];
   logic [1:0]   cnt_reg [SLICES];
   logic         pseudo_dual_port_ram_reg;
   logic         fastc_reg;
   logic         done_reg;
   logic         wait_reg;
   logic [31:0]  rdata_reg;
   tile_out_s    out_reg;

   logic [31:0]  rd_mux;
   logic [31:0]  wmerge;
   logic         bus_wr;
   logic         lut_hit;
   logic [2:0]   lut_sel;
   logic         ram_act;
   logic         ram_wr;
   logic [3:0]   waddr;
   logic [3:0]   laddr [LUTS];
   logic [7:0]   tbl_bit;
   logic [4:0]   five_input_table;
   logic [3:0]   wide;
   logic [3:0]   g_v;
   logic [3:0]   p_v;
   logic [3:0]   co_v;
   logic [1:0]   rip_f [SLICES];
   logic [3:0]   rip_x;
   tile_out_s    out_next;

   // ripple scratch
   logic         cin;
   logic         sub;
   logic         arith;
   logic [1:0]   opa;
   logic [1:0]   opb;
   logic [2:0]   gp;
   logic [2:0]   s3;
   logic         grp_g;
   logic         grp_p;

   function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (be[b])
         begin
            res[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return res;
   endfunction : merge_be

   // bus decode: one wait state, answer is always registered
   assign bus_wr  = avmm_in.write && !wait_reg;
   assign lut_hit = (avmm_in.address <= OFS_LUT_LAST);
   assign lut_sel = avmm_in.address[4:2];
   assign wmerge  = merge_be(rd_mux, avmm_in.writedata,
                             avmm_in.byteenable);

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (lut_hit)
      begin
         rd_mux[15:0] = lut_reg[lut_sel];
      end
      else
      begin
         case (avmm_in.address)
            OFS_MODE:
            begin
               for (int i = 0; i < SLICES; i++)
               begin
                  rd_mux[2*i +: 2] = mode_reg[i];
               end
               rd_mux[MODE_PSEUDO_DUAL_PORT_RAM_BIT]  = pseudo_dual_port_ram_reg;
               rd_mux[MODE_FASTC_BIT] = fastc_reg;
            end
            OFS_FUNC:
            begin
               for (int i = 0; i < SLICES; i++)
               begin
                  rd_mux[3*i +: 3] = fn_reg[i];
               end
            end
            OFS_CFG:
            begin
               rd_mux[CFG_DONE_BIT] = done_reg;
            end
            OFS_STATUS:
            begin
               for (int i = 0; i < SLICES; i++)
               begin
                  rd_mux[2*i +: 2] = cnt_reg[i];
               end
               rd_mux[STAT_RAM_BIT]  = ram_act;
               rd_mux[STAT_DONE_BIT] = done_reg;
            end
            default:
            begin
               rd_mux = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
      begin
         wait_reg  <= 1'b1;
         rdata_reg <= RDAT_RST;
      end
      else if ((avmm_in.read || avmm_in.write) && wait_reg)
      begin
         wait_reg  <= 1'b0;
         rdata_reg <= avmm_in.read ? rd_mux : RDAT_RST;
      end
      else
      begin
         wait_reg <= 1'b1;
      end
   end

   // mode and option registers
   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
      begin
         for (int i = 0; i < SLICES; i++)
         begin
            mode_reg[i] <= MODE_LOGIC;
            fn_reg[i]   <= FN_ADD;
         end
         pseudo_dual_port_ram_reg  <= 1'b0;
         fastc_reg <= 1'b0;
         done_reg  <= 1'b0;
      end
      else if (bus_wr)
      begin
         if (avmm_in.address == OFS_MODE)
         begin
            for (int i = 0; i < SLICES; i++)
            begin
               // slice 3 has no RAM wiring, so that code is refused
               if (!(i == 3 && wmerge[2*i +: 2] == MODE_RAM))
               begin
                  mode_reg[i] <= slice_mode_e'(wmerge[2*i +: 2]);
               end
            end
            pseudo_dual_port_ram_reg  <= wmerge[MODE_PSEUDO_DUAL_PORT_RAM_BIT];
            fastc_reg <= wmerge[MODE_FASTC_BIT];
         end
         if (avmm_in.address == OFS_FUNC)
         begin
            for (int i = 0; i < SLICES; i++)
            begin
               fn_reg[i] <= ripple_fn_e'(wmerge[3*i +: 3]);
            end
         end
         if (avmm_in.address == OFS_CFG)
         begin
            done_reg <= wmerge[CFG_DONE_BIT];
         end
      end
   end

   // slice 2 is the address and write-control slice of the RAM
   assign ram_act = (mode_reg[0] == MODE_RAM) && (mode_reg[1] == MODE_RAM)
                    && (mode_reg[2] == MODE_RAM);
   assign waddr   = {fabric_in.slice[2].d[0], fabric_in.slice[2].c[0],
                     fabric_in.slice[2].b[0], fabric_in.slice[2].a[0]};
   // no fabric write until preload is over
   assign ram_wr  = ram_act && done_reg
                    && fabric_in.slice[2].ctl;

   // table addresses and combinational lookups
   always_comb
   begin
      for (int k = 0; k < LUTS; k++)
      begin
         laddr[k] = {fabric_in.slice[k/2].d[k%2], fabric_in.slice[k/2].c[k%2],
                     fabric_in.slice[k/2].b[k%2], fabric_in.slice[k/2].a[k%2]};
         // companion slice keeps its own read address in pdp use
         if (ram_act && k < 4 && !(pseudo_dual_port_ram_reg && k >= 2))
         begin
            laddr[k] = waddr;
         end
         tbl_bit[k] = lut_reg[k][laddr[k]];
      end
   end

   // table storage: truth tables, RAM words and ROM contents
   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
      begin
         for (int k = 0; k < LUTS; k++)
         begin
            lut_reg[k] <= LUT_RST;
         end
      end
      else
      begin
         // bus writes preload or initialise; ROM locks once configured
         if (bus_wr && lut_hit &&
             !(done_reg && mode_reg[lut_sel[2:1]] == MODE_ROM))
         begin
            lut_reg[lut_sel] <= wmerge[15:0];
         end
         if (ram_wr && !pseudo_dual_port_ram_reg)
         begin
            lut_reg[0][waddr] <= fabric_in.slice[0].m0;
            lut_reg[1][waddr] <= fabric_in.slice[0].m1;
            lut_reg[2][waddr] <= fabric_in.slice[1].m0;
            lut_reg[3][waddr] <= fabric_in.slice[1].m1;
         end
         // one write lands in both copies at once
         if (ram_wr && pseudo_dual_port_ram_reg)
         begin
            lut_reg[0][waddr] <= fabric_in.slice[0].m0;
            lut_reg[1][waddr] <= fabric_in.slice[0].m1;
            lut_reg[2][waddr] <= fabric_in.slice[0].m0;
            lut_reg[3][waddr] <= fabric_in.slice[0].m1;
         end
      end
   end

   // wide functions: five inputs per slice, six and seven across slices
   always_comb
   begin
      for (int i = 0; i < SLICES; i++)
      begin
         five_input_table[i] = fabric_in.slice[i].m0 ? tbl_bit[2*i+1] : tbl_bit[2*i];
      end
      five_input_table[4] = fabric_in.slice[2].m1 ? five_input_table[3] : five_input_table[2];
      wide[0] = five_input_table[0];
      wide[1] = fabric_in.slice[1].m1 ? five_input_table[1] : five_input_table[0];
      wide[2] = five_input_table[2];
      // eight inputs need a second tile through routing
      wide[3] = fabric_in.slice[3].m1 ? five_input_table[4] : wide[1];
   end

   // ripple arithmetic with carry chained slice to slice
   always_comb
   begin
      cin   = fabric_in.carry_in;
      sub   = 1'b0;
      arith = 1'b0;
      opa   = 2'h0;
      opb   = 2'h0;
      gp    = 3'h0;
      s3    = 3'h0;
      for (int i = 0; i < SLICES; i++)
      begin
         arith = (fn_reg[i] == FN_ADD) || (fn_reg[i] == FN_SUB) ||
                 (fn_reg[i] == FN_ADDSUB) || (fn_reg[i] == FN_MULT);
         sub   = (fn_reg[i] == FN_SUB) ||
                 (fn_reg[i] == FN_ADDSUB && !fabric_in.slice[i].ctl);
         opa   = (fn_reg[i] == FN_MULT) ?
                 (fabric_in.slice[i].a & {2{fabric_in.slice[i].m0}}) :
                 fabric_in.slice[i].a;
         opb   = sub ? ~fabric_in.slice[i].b : fabric_in.slice[i].b;
         gp    = {1'b0, opa} + {1'b0, opb};
         s3    = gp + {2'h0, cin};
         g_v[i] = gp[2];
         p_v[i] = &(opa ^ opb);
         if (arith)
         begin
            rip_f[i] = s3[1:0];
            rip_x[i] = s3[2];
         end
         else if (fn_reg[i] == FN_CMP)
         begin
            rip_f[i] = {fabric_in.slice[i].a != fabric_in.slice[i].b,
                        fabric_in.slice[i].a >= fabric_in.slice[i].b};
            rip_x[i] = fabric_in.slice[i].a <= fabric_in.slice[i].b;
         end
         else
         begin
            rip_f[i] = cnt_reg[i];
            rip_x[i] = &cnt_reg[i];
         end
         if (mode_reg[i] == MODE_RIPPLE && arith)
         begin
            co_v[i] = fastc_reg ? (g_v[i] | (p_v[i] & cin)) : s3[2];
         end
         else
         begin
            co_v[i] = cin;
         end
         cin = co_v[i];
      end
   end

   // two-bit counters; in up/down mode clear beats preload beats count
   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
      begin
         for (int i = 0; i < SLICES; i++)
         begin
            cnt_reg[i] <= CNT_RST;
         end
      end
      else
      begin
         for (int i = 0; i < SLICES; i++)
         begin
            if (mode_reg[i] == MODE_RIPPLE)
            begin
               case (fn_reg[i])
                  FN_UP:
                  begin
                     if (fabric_in.slice[i].m0)
                     begin
                        cnt_reg[i] <= cnt_reg[i] + 2'h1;
                     end
                  end
                  FN_DOWN:
                  begin
                     if (fabric_in.slice[i].m0)
                     begin
                        cnt_reg[i] <= cnt_reg[i] - 2'h1;
                     end
                  end
                  FN_UPDOWN:
                  begin
                     if (fabric_in.cnt_clear)
                     begin
                        cnt_reg[i] <= CNT_RST;
                     end
                     else if (fabric_in.slice[i].ld)
                     begin
                        cnt_reg[i] <= fabric_in.slice[i].b;
                     end
                     else if (fabric_in.slice[i].m0)
                     begin
                        cnt_reg[i] <= fabric_in.slice[i].ctl ?
                                      cnt_reg[i] + 2'h1 : cnt_reg[i] - 2'h1;
                     end
                  end
                  default:
                  begin
                     cnt_reg[i] <= cnt_reg[i];
                  end
               endcase
            end
         end
      end
   end

   // output selection per slice mode
   always_comb
   begin
      out_next = '0;
      grp_g    = 1'b0;
      grp_p    = 1'b1;
      for (int i = 0; i < SLICES; i++)
      begin
         out_next.q[2*i +: 2] = cnt_reg[i];
         case (mode_reg[i])
            MODE_RIPPLE:
            begin
               out_next.f[2*i +: 2] = rip_f[i];
               out_next.ofx[i]      = rip_x[i];
            end
            MODE_RAM:
            begin
               // slice 2 only steers the memory, its f and ofx outputs stay low
               if (i < 2)
               begin
                  out_next.f[2*i +: 2] = {tbl_bit[2*i+1], tbl_bit[2*i]};
               end
            end
            default:
            begin
               out_next.f[2*i +: 2] = {tbl_bit[2*i+1], tbl_bit[2*i]};
               out_next.ofx[i]      = wide[i];
            end
         endcase
         grp_g = g_v[i] | (p_v[i] & grp_g);
         grp_p = grp_p & p_v[i];
      end
      out_next.carry_out = co_v[3];
      out_next.cgen      = fastc_reg & grp_g;
      out_next.cprop     = fastc_reg & grp_p;
   end

   // all routing outputs leave from flops
   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
      begin
         out_reg <= '0;
      end
      else
      begin
         out_reg <= out_next;
      end
   end

   assign fabric_out           = out_reg;
   assign avmm_out.readdata    = rdata_reg;
   assign avmm_out.waitrequest = wait_reg;

   // checks
   logic [1:0] add_chk;
   assign add_chk = 2'(fabric_in.slice[0].a + fabric_in.slice[0].b +
                       {1'b0, fabric_in.carry_in});

   AST_SLICE3_NO_RAM:
      assert property (@(posedge clk_in) disable iff (!resetn_in)
         mode_reg[3] != MODE_RAM)
      else $error("slice 3 entered RAM mode");

   AST_LOGIC_F0:
      assert property (@(posedge clk_in) disable iff (!resetn_in)
         mode_reg[0] == MODE_LOGIC |=> fabric_out.f[0] == $past(tbl_bit[0]))
      else $error("logic output does not follow truth table");

   AST_FIVE_INPUT_TABLE_SEL:
      assert property (@(posedge clk_in) disable iff (!resetn_in)
         (mode_reg[0] == MODE_LOGIC) && fabric_in.slice[0].m0
         |=> fabric_out.ofx[0] == $past(tbl_bit[1]))
      else $error("five-input select picked the wrong table");

   AST_LUT6_SEL:
      assert property (@(posedge clk_in) disable iff (!resetn_in)
         (mode_reg[1] == MODE_LOGIC) && !fabric_in.slice[1].m1 &&
         !fabric_in.slice[0].m0
         |=> fabric_out.ofx[1] == $past(tbl_bit[0]))
      else $error("six-input chain output wrong");

   AST_ADD:
      assert property (@(posedge clk_in) disable iff (!resetn_in)
         (mode_reg[0] == MODE_RIPPLE) && (fn_reg[0] == FN_ADD)
         |=> fabric_out.f[1:0] == $past(add_chk))
      else $error("two-bit sum wrong");

   AST_CNT_UP:
      assert property (@(posedge clk_in) disable iff (!resetn_in)
         (mode_reg[0] == MODE_RIPPLE) && (fn_reg[0] == FN_UP) &&
         fabric_in.slice[0].m0
         |=> cnt_reg[0] == $past(cnt_reg[0]) + 2'h1 ##1
             fabric_out.q[1:0] == $past(cnt_reg[0]))
      else $error("up counter did not step");

   AST_CNT_CLEAR:
      assert property (@(posedge clk_in) disable iff (!resetn_in)
         (mode_reg[1] == MODE_RIPPLE) && (fn_reg[1] == FN_UPDOWN) &&
         fabric_in.cnt_clear
         |=> cnt_reg[1] == CNT_RST ##1 fabric_out.q[3:2] == CNT_RST)
      else $error("counter clear ignored");

   AST_RAM_WRITE:
      assert property (@(posedge clk_in) disable iff (!resetn_in)
         ram_wr |=> lut_reg[0][$past(waddr)] == $past(fabric_in.slice[0].m0))
      else $error("RAM write not stored");

   AST_PSEUDO_DUAL_PORT_RAM_MIRROR:
      assert property (@(posedge clk_in) disable iff (!resetn_in)
         ram_wr && pseudo_dual_port_ram_reg
         |=> lut_reg[2][$past(waddr)] == lut_reg[0][$past(waddr)] &&
             lut_reg[3][$past(waddr)] == lut_reg[1][$past(waddr)])
      else $error("companion copy not updated");

   AST_NO_WR_PRELOAD:
      assert property (@(posedge clk_in) disable iff (!resetn_in)
         !done_reg && !bus_wr |=> $stable(lut_reg[0]))
      else $error("table changed during preload");

   AST_ROM_LOCK:
      assert property (@(posedge clk_in) disable iff (!resetn_in)
         done_reg && (mode_reg[3] == MODE_ROM) |=> $stable(lut_reg[6]))
      else $error("ROM contents changed after configuration");

   AST_BUS_ACK:
      assert property (@(posedge clk_in) disable iff (!resetn_in)
         (avmm_in.read || avmm_in.write) && wait_reg
         |=> !avmm_out.waitrequest ##1 avmm_out.waitrequest)
      else $error("bus answer not one wait state");

   COV_PSEUDO_DUAL_PORT_RAM_WRITE:
      cover property (@(posedge clk_in) disable iff (!resetn_in)
         ram_wr && pseudo_dual_port_ram_reg);

   COV_CNT_WRAP:
      cover property (@(posedge clk_in) disable iff (!resetn_in)
         fn_reg[0] == FN_UP && cnt_reg[0] == 2'h3 ##1 cnt_reg[0] == 2'h0);

   COV_CARRY_OUT:
      cover property (@(posedge clk_in) disable iff (!resetn_in)
         fastc_reg && out_next.carry_out && out_next.cgen);

   COV_LUT7:
      cover property (@(posedge clk_in) disable iff (!resetn_in)
         mode_reg[3] == MODE_LOGIC && fabric_in.slice[3].m1);

endmodule : logic_tile

`default_nettype wire
